// File: common/rel_pkg.sv
// ****************************************************************
// restrainable error log: shared constants and carriers
// ****************************************************************
package rel_pkg;

    // ************************************************************
    // register access space
    // ************************************************************
    localparam logic [7:0] REL_ASI_STATUS    = 8'h4C;
    localparam logic [7:0] REL_ASI_D1_LOG    = 8'h4D;
    localparam logic [7:0] REL_VA_STATUS     = 8'h00;
    localparam logic [7:0] REL_VA_D1_LOG     = 8'h00;

    // ************************************************************
    // status register layout
    // ************************************************************
    localparam int         REL_STAT_W        = 4;
    localparam int         REL_BIT_D1_INSD   = 0;
    localparam int         REL_BIT_L2_INSD   = 1;
    localparam int         REL_BIT_L2_FILL   = 2;
    localparam int         REL_BIT_ST_BUS    = 3;
    localparam logic [3:0] REL_STAT_RESET    = 4'h0;

    // ************************************************************
    // d1 fault address log layout
    // ************************************************************
    localparam int         REL_PRIO_MSB      = 63;
    localparam int         REL_PRIO_LSB      = 56;
    localparam int         REL_WAY_BIT       = 55;
    localparam int         REL_VA_MSB        = 50;
    localparam int         REL_VA_LSB        = 48;
    localparam int         REL_PA_MSB        = 42;
    localparam int         REL_PA_LSB        = 6;
    localparam logic [63:0] REL_D1_LOG_RESET = 64'h0;

    // ************************************************************
    // recording priorities and mark codes
    // ************************************************************
    localparam logic [7:0] REL_D1_PRIO_D1UE  = 8'h80;
    localparam logic [7:0] REL_L2_PRIO_FILL  = 8'h80;
    localparam logic [7:0] REL_L2_PRIO_INSD  = 8'hC0;
    localparam int         REL_MARK_W        = 12;
    localparam logic [REL_MARK_W-1:0] REL_MARK_FILL = 12'h000;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  asi;
        logic [7:0]  va;
        logic [63:0] wdata;
    } rel_asi_req_t;

    typedef struct packed {
        logic        st_bus_err;
        logic        st_timeout;
        logic        l2_fill_ue;
        logic        l2_wb_ue;
        logic        l2_refill_ue;
        logic        d1_ldst_ue;
        logic        d1_st_drop_ue;
        logic        d1_wb_ue;
    } rel_err_ev_t;

    typedef struct packed {
        logic        way;
        logic [2:0]  va15_13;
        logic [36:0] pa42_6;
    } rel_d1_loc_t;

    typedef struct packed {
        logic                  valid;
        logic [REL_MARK_W-1:0] code;
    } rel_mark_t;

endpackage

// File: rtl/rel_sticky_bits.sv
`timescale 1ns/1ps
// ****************************************************************
// write-one-clear sticky flag bank
// ****************************************************************
module rel_sticky_bits
    import rel_pkg::*;
(
    input  wire logic                  ref_clk_in, // core clock
    input  wire logic                  rst_b_in,   // hard power-on reset
    input  wire logic [REL_STAT_W-1:0] set_in,     // detector set pulses
    input  wire logic [REL_STAT_W-1:0] clr_in,     // software ones to clear
    output logic      [REL_STAT_W-1:0] flags_out   // sticky flags
);

    typedef struct packed {
        logic [REL_STAT_W-1:0] flags;
    } rel_sticky_state_t;

    rel_sticky_state_t state_reg;
    rel_sticky_state_t state_next;

    // set wins over a clear in the same cycle, so no event is lost
    always_comb begin
        state_next       = state_reg;
        state_next.flags = (state_reg.flags & ~clr_in) | set_in;
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_reg.flags <= REL_STAT_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign flags_out = state_reg.flags;

endmodule

// File: rtl/rel_error_log.sv
`timescale 1ns/1ps
// Functional notes
// - flag bit 3 when store data is lost after store completion.
// - bus error case: cacheable store hitting a noncacheable area.
// - timeout case: cacheable store to an area with no memory.
// - flag bit 2 on raw fill error; l2 priority 80h only.
// - mark the l2 doubleword of a raw fill error with code zero, unless an l2 writeback or refill error comes in the same cycle.
// - flag bit 1 on raw l2 error; mark data with source code.
// - bit 1 is set only for l2 writeback, never for l1 refill.
// - flag bit 0 on raw d1 error; d1 priority 80h only.
// - d1 flag raised when a load or store reads bad d1 data.
// - d1 flag also on dropped store data or d1 writeback error.
// - d1 error marks outgoing and d1 doubleword with source code; here only the d1 dword mark (d1_mark_out) is set.
// - reserved status bits read zero and ignore writes.
// - hard power-on reset clears the d1 log to zero.
// - other resets leave the d1 log unchanged.
// - d1 log updates only by each error's d1 priority.
// - any write clears the whole d1 log and rearms it.
// - status bits set on detection, clear only by writing one.
// - trap raised while a flag is set and traps are not disabled.
// - record only if priority exceeds stored type, then store it.
// - d1 log type field sits in bits 63 to 56.
module rel_error_log
    import rel_pkg::*;
(
    input  wire logic                  ref_clk_in,      // core clock
    input  wire logic                  rst_b_in,        // hard power-on
    input  wire rel_asi_req_t          asi_req_in,      // asi load/store
    input  wire rel_err_ev_t           err_ev_in,       // detector pulses
    input  wire rel_d1_loc_t           d1_loc_in,       // d1 error place
    input  wire logic [REL_MARK_W-1:0] mark_src_in,     // mark source reg
    input  wire logic                  trap_dis_in,     // trap disabled
    output logic      [63:0]           rdata_out,       // load data
    output logic                       rvalid_out,      // load data valid
    output logic                       ecc_trap_out,    // error trap
    output rel_mark_t                  l2_dw_mark_out,  // l2 dword mark
    output rel_mark_t                  l2_rd_mark_out,  // l2 read mark
    output rel_mark_t                  d1_mark_out,     // d1 dword mark
    output logic      [REL_STAT_W-1:0] status_out       // sticky flags
);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic [63:0] d1_log;
        logic [63:0] rdata;
        logic        rvalid;
        logic        trap;
        rel_mark_t   l2_dw_mark;
        rel_mark_t   l2_rd_mark;
        rel_mark_t   d1_mark;
    } rel_log_state_t;

    rel_log_state_t        state_reg;
    rel_log_state_t        state_next;
    logic [REL_STAT_W-1:0] stat_set;
    logic [REL_STAT_W-1:0] stat_clr;
    logic [REL_STAT_W-1:0] stat_q;
    logic                  hit_stat;
    logic                  hit_d1;
    logic                  d1_err;
    logic                  st_lost;
    logic [63:0]           d1_base;
    logic [7:0]            d1_prio_now;

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic asi_hit(input rel_asi_req_t r,
                                     input logic [7:0]   asi,
                                     input logic [7:0]   va);
        asi_hit = r.valid && (r.asi == asi) && (r.va == va);
    endfunction

    function automatic logic prio_wins(input logic [7:0] p_new,
                                       input logic [7:0] p_held);
        prio_wins = p_new > p_held;
    endfunction

    function automatic logic [63:0] d1_pack(input logic [7:0]  prio,
                                            input rel_d1_loc_t loc);
        logic [63:0] v;
        v = 64'h0;
        v[REL_PRIO_MSB:REL_PRIO_LSB] = prio;
        v[REL_WAY_BIT]               = loc.way;
        v[REL_VA_MSB:REL_VA_LSB]     = loc.va15_13;
        v[REL_PA_MSB:REL_PA_LSB]     = loc.pa42_6;
        d1_pack = v;
    endfunction

    // ************************************************************
    // address decode
    // ************************************************************
    always_comb begin
        hit_stat = asi_hit(asi_req_in, REL_ASI_STATUS, REL_VA_STATUS);
        hit_d1   = asi_hit(asi_req_in, REL_ASI_D1_LOG, REL_VA_D1_LOG);
    end

    // ************************************************************
    // error classification
    // ************************************************************
    always_comb begin
        // either cause means the completed store never reached memory
        st_lost = err_ev_in.st_bus_err
                | err_ev_in.st_timeout;
        d1_err  = err_ev_in.d1_ldst_ue
                | err_ev_in.d1_st_drop_ue
                | err_ev_in.d1_wb_ue;
        stat_set                  = '0;
        stat_set[REL_BIT_ST_BUS]  = st_lost;
        stat_set[REL_BIT_L2_FILL] = err_ev_in.l2_fill_ue;
        // refill detections are marked but deliberately not flagged
        stat_set[REL_BIT_L2_INSD] = err_ev_in.l2_wb_ue;
        stat_set[REL_BIT_D1_INSD] = d1_err;
    end

    // ************************************************************
    // software clear of status bits
    // ************************************************************
    always_comb begin
        stat_clr = '0;
        if (hit_stat && asi_req_in.write) begin
            // only the implemented low bits reach the flags
            stat_clr = asi_req_in.wdata[REL_STAT_W-1:0];
        end
    end

    rel_sticky_bits u_sticky (
        .ref_clk_in (ref_clk_in),
        .rst_b_in   (rst_b_in),
        .set_in     (stat_set),
        .clr_in     (stat_clr),
        .flags_out  (stat_q)
    );

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        state_next  = state_reg;
        d1_base     = state_reg.d1_log;
        d1_prio_now = 8'h00;

        // a write empties the log whatever the data carries
        if (hit_d1 && asi_req_in.write) begin
            d1_base = 64'h0;
        end
        d1_prio_now = d1_base[REL_PRIO_MSB:REL_PRIO_LSB];

        // only the d1 data error has a d1 priority; the store loss
        // and both l2 errors never touch this log
        state_next.d1_log = d1_base;
        if (d1_err && prio_wins(REL_D1_PRIO_D1UE, d1_prio_now)) begin
            // a write in the same cycle still lets the new error in
            state_next.d1_log = d1_pack(REL_D1_PRIO_D1UE,
                                        d1_loc_in);
        end

        // load answer, one cycle after the request
        state_next.rvalid = asi_req_in.valid && !asi_req_in.write;
        state_next.rdata  = 64'h0;
        if (asi_req_in.valid && !asi_req_in.write) begin
            if (hit_stat) begin
                state_next.rdata[REL_STAT_W-1:0] = stat_q;
            end else if (hit_d1) begin
                state_next.rdata = state_reg.d1_log;
            end
        end

        // trap follows the flags as they stand this cycle
        state_next.trap = (|stat_q) && !trap_dis_in;

        // poison marks for the cache arrays and the data path
        state_next.l2_dw_mark = '0;
        state_next.l2_rd_mark = '0;
        state_next.d1_mark    = '0;
        if (err_ev_in.l2_fill_ue) begin
            state_next.l2_dw_mark.valid = 1'b1;
            state_next.l2_dw_mark.code  = REL_MARK_FILL;
        end
        // inside errors win the dword mark: the source code is more
        // telling than the fixed fill code
        if (err_ev_in.l2_wb_ue || err_ev_in.l2_refill_ue) begin
            state_next.l2_dw_mark.valid = 1'b1;
            state_next.l2_dw_mark.code  = mark_src_in;
            state_next.l2_rd_mark.valid = 1'b1;
            state_next.l2_rd_mark.code  = mark_src_in;
        end
        if (d1_err) begin
            state_next.d1_mark.valid = 1'b1;
            state_next.d1_mark.code  = mark_src_in;
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    // rst_b_in is the hard power-on reset only; lighter resets are
    // not wired here so the log survives them
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_reg.d1_log     <= REL_D1_LOG_RESET;
            state_reg.rdata      <= 64'h0;
            state_reg.rvalid     <= 1'b0;
            state_reg.trap       <= 1'b0;
            state_reg.l2_dw_mark <= '0;
            state_reg.l2_rd_mark <= '0;
            state_reg.d1_mark    <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign rdata_out      = state_reg.rdata;
    assign rvalid_out     = state_reg.rvalid;
    assign ecc_trap_out   = state_reg.trap;
    assign l2_dw_mark_out = state_reg.l2_dw_mark;
    assign l2_rd_mark_out = state_reg.l2_rd_mark;
    assign d1_mark_out    = state_reg.d1_mark;
    assign status_out     = stat_q;

endmodule

// File: verification/rel_error_log_properties.sv
`timescale 1ns/1ps
module rel_error_log_properties
    import rel_pkg::*;
(
    input wire logic                  ref_clk_in,     // core clock
    input wire logic                  rst_b_in,       // hard reset
    input wire rel_asi_req_t          asi_req_in,     // asi access
    input wire rel_err_ev_t           err_ev_in,      // detector pulses
    input wire rel_d1_loc_t           d1_loc_in,      // d1 error place
    input wire logic [REL_MARK_W-1:0] mark_src_in,    // mark source
    input wire logic                  trap_dis_in,    // trap disable
    input wire logic [63:0]           rdata_out,      // load data
    input wire logic                  rvalid_out,     // load valid
    input wire logic                  ecc_trap_out,   // error trap
    input wire rel_mark_t             l2_dw_mark_out, // l2 dword mark
    input wire rel_mark_t             l2_rd_mark_out, // l2 read mark
    input wire rel_mark_t             d1_mark_out,    // d1 dword mark
    input wire logic [REL_STAT_W-1:0] status_out      // sticky flags
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_b_in);
    logic st_acc;
    logic d1_ev;
    logic trap_cond;
    assign st_acc = asi_req_in.valid && asi_req_in.asi == REL_ASI_STATUS
                    && asi_req_in.va == REL_VA_STATUS;
    assign d1_ev = err_ev_in.d1_ldst_ue || err_ev_in.d1_st_drop_ue
                   || err_ev_in.d1_wb_ue;
    assign trap_cond = (|status_out) && !trap_dis_in;

    AST_STORE_LOSS: assert property (
        err_ev_in.st_bus_err || err_ev_in.st_timeout |=> status_out[3])
        else $error("store loss flag not set");
    AST_FILL_FLAG: assert property (
        err_ev_in.l2_fill_ue |=> status_out[2] && l2_dw_mark_out.valid)
        else $error("fill flag or mark missing");
    AST_FILL_MARK: assert property (
        err_ev_in.l2_fill_ue && !err_ev_in.l2_wb_ue
        && !err_ev_in.l2_refill_ue
        |=> l2_dw_mark_out.code == REL_MARK_FILL)
        else $error("fill mark code not zero");
    AST_WB_MARK: assert property (
        err_ev_in.l2_wb_ue |=> status_out[1] && l2_rd_mark_out.valid
        && l2_rd_mark_out.code == $past(mark_src_in)
        && l2_dw_mark_out.code == $past(mark_src_in))
        else $error("l2 inside flag or mark wrong");
    AST_NO_REFILL_FLAG: assert property (
        !status_out[1] && !err_ev_in.l2_wb_ue |=> !status_out[1])
        else $error("l2 inside flag set without writeback");
    AST_D1_FLAG: assert property (
        d1_ev |=> status_out[0] && d1_mark_out.valid
        && d1_mark_out.code == $past(mark_src_in))
        else $error("d1 flag or mark wrong");
    AST_STICKY: assert property (
        status_out[0] && !(st_acc && asi_req_in.write
        && asi_req_in.wdata[0]) |=> status_out[0])
        else $error("flag lost without write one");
    AST_TRAP: assert property (
        1'b1 |=> ecc_trap_out == $past(trap_cond))
        else $error("trap does not follow flags");
    AST_RSV_ZERO: assert property (
        st_acc && !asi_req_in.write
        |=> rvalid_out && rdata_out[63:4] == 60'h0)
        else $error("status read bad");
    COV_D1: cover property (d1_ev ##2 ecc_trap_out);
    COV_WB: cover property (err_ev_in.l2_wb_ue ##1 l2_rd_mark_out.valid);
    COV_CLR: cover property (status_out[0] ##1 !status_out[0]);
endmodule

bind rel_error_log rel_error_log_properties u_props (
    .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .asi_req_in(asi_req_in),
    .err_ev_in(err_ev_in), .d1_loc_in(d1_loc_in),
    .mark_src_in(mark_src_in), .trap_dis_in(trap_dis_in),
    .rdata_out(rdata_out), .rvalid_out(rvalid_out),
    .ecc_trap_out(ecc_trap_out), .l2_dw_mark_out(l2_dw_mark_out),
    .l2_rd_mark_out(l2_rd_mark_out), .d1_mark_out(d1_mark_out),
    .status_out(status_out));

// File: verification/rel_det_model.sv
`timescale 1ns/1ps
module rel_det_model
    import rel_pkg::*;
(
    input  wire logic  ref_clk_in, // core clock
    output rel_err_ev_t ev_out,    // detector pulses
    output rel_d1_loc_t loc_out    // d1 error place
);
    initial begin
        ev_out = '0;
        loc_out = '0;
    end
    // place lines go inverse after the pulse so a stale value never helps
    task automatic fire(input int idx, input rel_d1_loc_t loc);
        @(negedge ref_clk_in);
        ev_out = rel_err_ev_t'(8'h80 >> idx);
        loc_out = loc;
        @(negedge ref_clk_in);
        ev_out = '0;
        loc_out = ~loc;
    endtask
endmodule

// File: verification/tb_restrainable_error_status_log.sv
`timescale 1ns/1ps
module tb_restrainable_error_status_log;
    import rel_pkg::*;
    logic                  ref_clk_in;
    logic                  rst_b_in;
    rel_asi_req_t          req;
    rel_err_ev_t           ev;
    rel_d1_loc_t           loc;
    rel_d1_loc_t           l1;
    logic [REL_MARK_W-1:0] mark_src;
    logic                  trap_dis;
    logic [63:0]           rdata;
    logic                  rvalid;
    logic                  trap;
    rel_mark_t             dw_mark;
    rel_mark_t             rd_mark;
    rel_mark_t             d1_mark;
    rel_mark_t             em;
    logic [3:0]            sb;
    logic [REL_STAT_W-1:0] status;
    int                    err_count;
    int                    cmp_count;

    rel_error_log u_rel_error_log (
        .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .asi_req_in(req),
        .err_ev_in(ev), .d1_loc_in(loc), .mark_src_in(mark_src),
        .trap_dis_in(trap_dis), .rdata_out(rdata), .rvalid_out(rvalid),
        .ecc_trap_out(trap), .l2_dw_mark_out(dw_mark),
        .l2_rd_mark_out(rd_mark), .d1_mark_out(d1_mark),
        .status_out(status));
    rel_det_model u_rel_det_model (
        .ref_clk_in(ref_clk_in), .ev_out(ev), .loc_out(loc));

    initial begin
        ref_clk_in = 1'b0;
        forever #2.5 ref_clk_in = ~ref_clk_in;
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chkm(input rel_mark_t got, input rel_mark_t exp);
        chk(64'(got), 64'(exp));
    endtask
    task automatic acc(input logic wr, input logic [7:0] asi,
                       input logic [63:0] wd);
        @(negedge ref_clk_in);
        req = '{1'b1, wr, asi, 8'h00, wd};
        @(negedge ref_clk_in);
        req.valid = 1'b0;
    endtask
    task automatic rd(input logic [7:0] asi, input logic [63:0] exp);
        acc(1'b0, asi, 64'h0);
        chk(64'(rvalid), 64'h1);
        chk(rdata, exp);
    endtask
    function automatic logic [63:0] exp_log(input rel_d1_loc_t l);
        return {REL_D1_PRIO_D1UE, l.way, 4'h0, l.va15_13, 5'h00,
                l.pa42_6, 6'h00};
    endfunction
    function automatic logic [3:0] exp_bit(input int i);
        case (i)
            0, 1: return 4'h8;
            2: return 4'h4;
            3: return 4'h2;
            4: return 4'h0;
            default: return 4'h1;
        endcase
    endfunction
    task automatic results();
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // run needs some 190 cycles; the limit leaves wide margin
    initial begin
        #200000;
        err_count++;
        results();
    end

    initial begin
        rst_b_in = 1'b0;
        req = '0;
        mark_src = '0;
        trap_dis = 1'b0;
        err_count = 0;
        cmp_count = 0;
        void'($urandom(27548));
        repeat (10) @(negedge ref_clk_in);
        rst_b_in = 1'b1;
        rd(REL_ASI_STATUS, 64'h0);
        rd(REL_ASI_D1_LOG, REL_D1_LOG_RESET);
        acc(1'b1, REL_ASI_STATUS, 64'hFFFF_FFFF_FFFF_FFF0);
        rd(REL_ASI_STATUS, 64'h0);
        rd(8'h4E, 64'h0);
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            l1 = 41'({$urandom, $urandom});
            mark_src = REL_MARK_W'($urandom);
            trap_dis = 1'($urandom);
            sb = exp_bit(i);
            em = '0;
            if (i == 2) em = {1'b1, REL_MARK_FILL};
            if (i == 3 || i == 4) em = {1'b1, mark_src};
            u_rel_det_model.fire(i, l1);
            chkm(d1_mark, i > 4 ? {1'b1, mark_src} : 13'h0);
            chkm(dw_mark, em);
            chkm(rd_mark, i == 2 ? 13'h0 : em);
            @(negedge ref_clk_in);
            chk(64'(trap), 64'(sb != 4'h0 && !trap_dis));
            chk(64'(status), 64'(sb));
            if (i > 4) u_rel_det_model.fire(7 - i + 5, ~l1);
            rd(REL_ASI_D1_LOG, i > 4 ? exp_log(l1) : 64'h0);
            acc(1'b1, REL_ASI_D1_LOG, {$urandom, $urandom});
            rd(REL_ASI_D1_LOG, 64'h0);
            rd(REL_ASI_STATUS, 64'(sb));
            acc(1'b1, REL_ASI_STATUS, {$urandom, $urandom} & ~64'(sb));
            rd(REL_ASI_STATUS, 64'(sb));
            acc(1'b1, REL_ASI_STATUS, 64'(sb));
            rd(REL_ASI_STATUS, 64'h0);
            $display("test event %0d done", i);
        end
        // same-cycle corners: a detector set beats a clear, an error
        // beats a wipe of the log
        fork
            acc(1'b1, REL_ASI_STATUS, 64'h1);
            u_rel_det_model.fire(5, l1);
        join
        rd(REL_ASI_STATUS, 64'h1);
        fork
            acc(1'b1, REL_ASI_D1_LOG, {$urandom, $urandom});
            u_rel_det_model.fire(6, ~l1);
        join
        rd(REL_ASI_D1_LOG, exp_log(~l1));
        $display("test corner done");
        // second hard reset in mid-run must empty a filled log
        @(negedge ref_clk_in);
        rst_b_in = 1'b0;
        repeat (2) @(negedge ref_clk_in);
        rst_b_in = 1'b1;
        rd(REL_ASI_D1_LOG, REL_D1_LOG_RESET);
        rd(REL_ASI_STATUS, 64'h0);
        $display("test reset two done");
        results();
    end
endmodule
